// >>> src/csbl_pkg.sv
// Package of constants and types for the chip-select and lane decoder
package csbl_pkg;

  localparam int NUM_SELECTS = 8;
  localparam int BASE_MSB    = 31;
  localparam int BASE_LSB    = 16;
  localparam int BASE_W      = BASE_MSB - BASE_LSB + 1;
  localparam int WAIT_W      = 4;
  localparam int LANES       = 4;

  // Boot strap positions on the data pins
  localparam int STRAP_AA_BIT  = 7;
  localparam int STRAP_PW_MSB  = 6;
  localparam int STRAP_PW_LSB  = 5;

  localparam logic [WAIT_W-1:0] BOOT_AA_WAIT  = 4'hF;
  localparam logic [WAIT_W-1:0] WAIT_RESET    = 4'h0;
  localparam logic [LANES-1:0]  LANES_IDLE    = 4'hF;
  localparam logic [NUM_SELECTS-1:0] SEL_IDLE = 8'hFF;

  typedef enum logic [1:0] {
    CSBL_PW_32  = 2'b00,
    CSBL_PW_8   = 2'b01,
    CSBL_PW_16  = 2'b10,
    CSBL_PW_16B = 2'b11
  } csbl_width_t;

  typedef enum logic [1:0] {
    CSBL_SZ_LONG = 2'b00,
    CSBL_SZ_BYTE = 2'b01,
    CSBL_SZ_WORD = 2'b10,
    CSBL_SZ_LINE = 2'b11
  } csbl_size_t;

  localparam csbl_width_t BOOT_PW_RESET = CSBL_PW_32;

endpackage

// >>> src/csbl_lane_if.sv
// Interface between the select decoder and the lane strobe decoder
`timescale 1ns/1ps
interface csbl_lane_if;
  import csbl_pkg::*;
  csbl_size_t        size;
  logic [1:0]        addr_low;
  csbl_width_t       width;
  logic [LANES-1:0]  lanes_n;
  modport requester (output size, output addr_low, output width,
                     input lanes_n);
  modport decoder   (input size, input addr_low, input width,
                     output lanes_n);
endinterface

// >>> src/csbl_lane_decode.sv
// Combinational byte-lane strobe decoder
`timescale 1ns/1ps
module csbl_lane_decode
  import csbl_pkg::*;
(
  csbl_lane_if.decoder lane
);

  function automatic logic [LANES-1:0] lane_pattern(
    input csbl_size_t  size,
    input logic [1:0]  a,
    input csbl_width_t width
  );
    logic [LANES-1:0] p;
    p = LANES_IDLE;
    case (width)
      CSBL_PW_8: begin
        p = 4'hE;
      end
      CSBL_PW_16, CSBL_PW_16B: begin
        if (size == CSBL_SZ_BYTE) begin
          p = a[0] ? 4'hD : 4'hE;
        end else begin
          p = 4'hC;
        end
      end
      CSBL_PW_32: begin
        case (size)
          CSBL_SZ_BYTE: p = ~(4'h1 << a);
          CSBL_SZ_WORD: p = a[1] ? 4'h3 : 4'hC;
          default:      p = 4'h0;
        endcase
      end
      default: p = LANES_IDLE;
    endcase
    return p;
  endfunction

  // Bit 0 is lane 0, the most significant data byte
  always_comb begin
    lane.lanes_n = lane_pattern(lane.size, lane.addr_low, lane.width);
  end

endmodule

// >>> src/csbl_select_decode.sv
// Chip-select, output enable and byte-lane strobe decoder
`timescale 1ns/1ps
module csbl_select_decode
  import csbl_pkg::*;
#(
  parameter int NSEL = NUM_SELECTS
)(
  input  wire logic                         clock,
  input  wire logic                         reset,
  input  wire logic                         reset_input_n,
  input  wire logic [7:0]                   data_pin_in,
  input  wire logic [NSEL-1:0][BASE_W-1:0]  select_base,
  input  wire logic [NSEL-1:0][BASE_W-1:0]  select_mask,
  input  wire logic [NSEL-1:0]              select_valid,
  input  wire logic [NSEL-1:0][1:0]         port_width,
  input  wire logic [NSEL-1:0]              lane_strobe_mode,
  input  wire logic [NSEL-1:0]              auto_acknowledge,
  input  wire logic [NSEL-1:0][WAIT_W-1:0]  select_wait,
  input  wire logic [NSEL-1:0]              select_burst_read,
  input  wire logic [NSEL-1:0]              select_burst_write,
  input  wire logic                         xfer_valid,
  input  wire logic                         xfer_read,
  input  wire logic [31:0]                  xfer_addr,
  input  wire logic [1:0]                   xfer_size,
  output logic      [NSEL-1:0]              select_n,
  output logic      [LANES-1:0]             lane_strobe_n,
  output logic                              lane_write_mode,
  output logic                              output_enable_n,
  output logic      [1:0]                   active_width,
  output logic                              active_auto_ack,
  output logic      [WAIT_W-1:0]            active_wait,
  output logic                              active_burst,
  output logic                              access_external,
  output logic                              boot_global
);

  function automatic logic addr_hit(
    input logic [BASE_W-1:0] addr_hi,
    input logic [BASE_W-1:0] base,
    input logic [BASE_W-1:0] mask
  );
    return ((addr_hi ^ base) & ~mask) == '0;
  endfunction

  // Boot strap capture
  logic              rstin_prev_reg, rstin_prev_next;
  logic              boot_aa_reg, boot_aa_next;
  csbl_width_t       boot_pw_reg, boot_pw_next;
  logic              boot_mode_reg, boot_mode_next;
  logic              global_reg, global_next;

  // Strap is taken on the clock where the reset input is seen released
  always_comb begin
    rstin_prev_next = reset_input_n;
    boot_aa_next    = boot_aa_reg;
    boot_pw_next    = boot_pw_reg;
    boot_mode_next  = boot_mode_reg;
    global_next     = global_reg;
    if (!reset_input_n) begin
      global_next = 1'b1;
    end else if (!rstin_prev_reg) begin
      boot_aa_next   = data_pin_in[STRAP_AA_BIT];
      boot_mode_next = data_pin_in[STRAP_AA_BIT];
      boot_pw_next   = csbl_width_t'(
                         data_pin_in[STRAP_PW_MSB:STRAP_PW_LSB]);
    end else if (select_valid[0]) begin
      // Global decode ends once select 0 is validated, until the reset input is asserted again
      global_next = 1'b0;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      rstin_prev_reg <= 1'b0;
      boot_aa_reg    <= 1'b0;
      boot_pw_reg    <= BOOT_PW_RESET;
      boot_mode_reg  <= 1'b0;
      global_reg     <= 1'b1;
    end else begin
      rstin_prev_reg <= rstin_prev_next;
      boot_aa_reg    <= boot_aa_next;
      boot_pw_reg    <= boot_pw_next;
      boot_mode_reg  <= boot_mode_next;
      global_reg     <= global_next;
    end
  end

  // Address match
  logic [NSEL-1:0] hit;
  logic            any_hit;
  logic            multi_hit;
  int unsigned     hit_idx;

  always_comb begin
    hit     = '0;
    hit_idx = 0;
    for (int i = 0; i < NSEL; i++) begin
      if (global_reg) begin
        hit[i] = (i == 0);
      end else begin
        hit[i] = select_valid[i] &&
                 addr_hit(xfer_addr[BASE_MSB:BASE_LSB],
                          select_base[i], select_mask[i]);
      end
      if (hit[i]) begin
        hit_idx = i;
      end
    end
    any_hit   = xfer_valid && (hit != '0);
    multi_hit = (hit & (hit - 1'b1)) != '0;
  end

  // Selected attributes
  csbl_width_t        eff_width;
  logic               eff_aa;
  logic [WAIT_W-1:0]  eff_wait;
  logic               eff_burst;
  logic               eff_mode;

  always_comb begin
    eff_width = CSBL_PW_32;
    eff_aa    = 1'b0;
    eff_wait  = WAIT_RESET;
    eff_burst = 1'b0;
    eff_mode  = 1'b0;
    if (global_reg) begin
      eff_width = boot_pw_reg;
      eff_aa    = boot_aa_reg;
      eff_wait  = boot_aa_reg ? BOOT_AA_WAIT : WAIT_RESET;
      eff_mode  = boot_mode_reg;
    end else if (multi_hit) begin
      // Overlap: external, burst-inhibited, 32-bit
      eff_mode = lane_strobe_mode[hit_idx];
    end else if (any_hit) begin
      eff_width = csbl_width_t'(port_width[hit_idx]);
      eff_aa    = auto_acknowledge[hit_idx];
      eff_wait  = select_wait[hit_idx];
      eff_burst = xfer_read ? select_burst_read[hit_idx]
                            : select_burst_write[hit_idx];
      eff_mode  = lane_strobe_mode[hit_idx];
    end
  end

  // Lane decode
  csbl_lane_if lane_bus ();

  assign lane_bus.size     = csbl_size_t'(xfer_size);
  assign lane_bus.addr_low = xfer_addr[1:0];
  assign lane_bus.width    = eff_width;

  csbl_lane_decode u_lane (
    .lane (lane_bus.decoder)
  );

  // Registered outputs, rising edge
  logic [NSEL-1:0]   sel_reg, sel_next;
  logic [LANES-1:0]  lanes_reg, lanes_next;
  logic              wmode_reg, wmode_next;
  logic [1:0]        width_reg, width_next;
  logic              aa_reg, aa_next;
  logic [WAIT_W-1:0] wait_reg, wait_next;
  logic              burst_reg, burst_next;
  logic              ext_reg, ext_next;

  always_comb begin
    sel_next   = SEL_IDLE;
    lanes_next = LANES_IDLE;
    wmode_next = 1'b0;
    width_next = CSBL_PW_32;
    aa_next    = 1'b0;
    wait_next  = WAIT_RESET;
    burst_next = 1'b0;
    ext_next   = xfer_valid;
    if (any_hit) begin
      sel_next   = ~hit;
      lanes_next = lane_bus.lanes_n;
      wmode_next = eff_mode;
      width_next = eff_width;
      aa_next    = eff_aa;
      wait_next  = eff_wait;
      burst_next = eff_burst;
      ext_next   = multi_hit || !eff_aa;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      sel_reg   <= SEL_IDLE;
      lanes_reg <= LANES_IDLE;
      wmode_reg <= 1'b0;
      width_reg <= CSBL_PW_32;
      aa_reg    <= 1'b0;
      wait_reg  <= WAIT_RESET;
      burst_reg <= 1'b0;
      ext_reg   <= 1'b0;
    end else begin
      sel_reg   <= sel_next;
      lanes_reg <= lanes_next;
      wmode_reg <= wmode_next;
      width_reg <= width_next;
      aa_reg    <= aa_next;
      wait_reg  <= wait_next;
      burst_reg <= burst_next;
      ext_reg   <= ext_next;
    end
  end

  // Output enable, falling edge
  logic oe_n_reg, oe_n_next;

  // Half a cycle after the rising edge gives memory setup time on reads
  always_comb begin
    oe_n_next = !(any_hit && xfer_read);
  end

  always_ff @(negedge clock or posedge reset) begin
    if (reset) begin
      oe_n_reg <= 1'b1;
    end else begin
      oe_n_reg <= oe_n_next;
    end
  end

  assign select_n        = sel_reg;
  assign lane_strobe_n   = lanes_reg;
  assign lane_write_mode = wmode_reg;
  assign output_enable_n = oe_n_reg;
  assign active_width    = width_reg;
  assign active_auto_ack = aa_reg;
  assign active_wait     = wait_reg;
  assign active_burst    = burst_reg;
  assign access_external = ext_reg;
  assign boot_global     = global_reg;

  // Assertions
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  a_idle_lanes_high: assert property (
    !$past(any_hit) |-> (lane_strobe_n == LANES_IDLE))
    else $error("lanes active without select access");

  a_oe_read_only: assert property (
    !output_enable_n |-> (any_hit && xfer_read))
    else $error("output enable asserted on non-matching access");

  a_oe_falling_only: assert property (
    @(negedge clock) disable iff (reset)
    $past(reset) || output_enable_n == $past(oe_n_next))
    else $error("output enable moved on a rising edge");

  a_eight_bit_lane: assert property (
    $past(any_hit && eff_width == CSBL_PW_8) |-> lane_strobe_n == 4'hE)
    else $error("8-bit port lane mismatch");

  a_sixteen_bit_lane: assert property (
    $past(any_hit && eff_width[1]) |->
      lane_strobe_n == (($past(xfer_size) == CSBL_SZ_BYTE)
        ? ($past(xfer_addr[0]) ? 4'hD : 4'hE) : 4'hC))
    else $error("16-bit port lane mismatch");

  a_byte_lane_32: assert property (
    $past(any_hit && eff_width == CSBL_PW_32 &&
          xfer_size == CSBL_SZ_BYTE) |->
      lane_strobe_n == ~(4'h1 << $past(xfer_addr[1:0])))
    else $error("32-bit byte lane mismatch");

  a_word_lane_32: assert property (
    $past(any_hit && eff_width == CSBL_PW_32 &&
          xfer_size == CSBL_SZ_WORD) |->
      lane_strobe_n == ($past(xfer_addr[1]) ? 4'h3 : 4'hC))
    else $error("32-bit word lane mismatch");

  a_boot_strap_aa: assert property (
    (reset_input_n && !rstin_prev_reg) |=>
      boot_aa_reg == $past(data_pin_in[STRAP_AA_BIT]))
    else $error("boot acknowledge strap not captured");

  a_boot_wait_15: assert property (
    $past(global_reg && any_hit && boot_aa_reg) |->
      (active_wait == BOOT_AA_WAIT && active_auto_ack))
    else $error("boot select lacks 15 waits");

  a_global_select: assert property (
    $past(global_reg && xfer_valid) |-> select_n == 8'hFE)
    else $error("global boot select not asserted alone");

  a_mode_follows: assert property (
    $past(any_hit && !global_reg && !multi_hit) |->
      lane_write_mode == $past(lane_strobe_mode[hit_idx]))
    else $error("lane strobe mode not taken from select");

  c_boot_read:   cover property (global_reg && any_hit && xfer_read);
  c_multi_hit:   cover property (any_hit && multi_hit);
  c_normal_write: cover property (!global_reg && any_hit && !xfer_read);
  c_global_end:  cover property ($fell(global_reg));

endmodule

// >>> sim/csbl_mem_model.sv
// Behavioural external memory watching select, enable and lane pins
`timescale 1ns/1ps
module csbl_mem_model (
  input  wire logic       clock,
  input  wire logic [7:0] select_n,
  input  wire logic [3:0] lane_strobe_n,
  input  wire logic       output_enable_n,
  output int              oe_faults
);
  initial oe_faults = 0;
  // Unselected part would fight the bus if its enable came alone
  always @(negedge clock) begin
    if (!output_enable_n && (&select_n || lane_strobe_n == 4'hF))
      oe_faults <= oe_faults + 1;
  end
endmodule

// >>> sim/tb.sv
// Self-checking bench for the chip-select and lane decoder
`timescale 1ns/1ps
module tb;
  import csbl_pkg::*;
  logic             clock, reset, reset_input_n, xfer_valid, xfer_read;
  logic [7:0]       data_pin_in, select_valid, lane_strobe_mode;
  logic [7:0]       auto_acknowledge, burst_r, burst_w, select_n;
  logic [7:0][15:0] select_base, select_mask;
  logic [7:0][1:0]  port_width;
  logic [7:0][3:0]  select_wait;
  logic [31:0]      xfer_addr, rng;
  logic [1:0]       xfer_size, active_width;
  logic [3:0]       lane_strobe_n, active_wait;
  logic             lane_write_mode, output_enable_n, active_auto_ack;
  logic             active_burst, access_external, boot_global, glob;
  logic [2:0]       strap;
  int               bad_count, compares, oe_faults;

  csbl_select_decode i_csbl_select_decode (
    .clock(clock), .reset(reset), .reset_input_n(reset_input_n),
    .data_pin_in(data_pin_in), .select_base(select_base),
    .select_mask(select_mask), .select_valid(select_valid),
    .port_width(port_width), .lane_strobe_mode(lane_strobe_mode),
    .auto_acknowledge(auto_acknowledge), .select_wait(select_wait),
    .select_burst_read(burst_r), .select_burst_write(burst_w),
    .xfer_valid(xfer_valid), .xfer_read(xfer_read),
    .xfer_addr(xfer_addr), .xfer_size(xfer_size), .select_n(select_n),
    .lane_strobe_n(lane_strobe_n), .lane_write_mode(lane_write_mode),
    .output_enable_n(output_enable_n), .active_width(active_width),
    .active_auto_ack(active_auto_ack), .active_wait(active_wait),
    .active_burst(active_burst), .access_external(access_external),
    .boot_global(boot_global));

  csbl_mem_model i_csbl_mem_model (
    .clock(clock), .select_n(select_n), .lane_strobe_n(lane_strobe_n),
    .output_enable_n(output_enable_n), .oe_faults(oe_faults));

  function automatic logic [31:0] rnd();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction

  function automatic logic [3:0] lanes_exp(logic [1:0] w, logic [1:0] sz,
                                           logic [1:0] a);
    if (w == 2'h1) return 4'hE;
    if (w[1]) return (sz != 2'h1) ? 4'hC : (a[0] ? 4'hD : 4'hE);
    if (sz == 2'h1) return ~(4'h1 << a);
    if (sz == 2'h2) return a[1] ? 4'h3 : 4'hC;
    return 4'h0;
  endfunction

  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic tick();
    @(posedge clock);
    #1;
  endtask

  task automatic access(input logic rd, input logic [15:0] hi,
                        input logic [1:0] sz);
    logic [7:0] hits;
    logic [1:0] a, w;
    logic [3:0] le;
    logic       aa, oe;
    int         n, k;
    a = 2'(rnd());
    if (sz == 2'h2) a[0] = 1'b0;
    if (sz[0] == sz[1]) a = 2'h0;
    hits = 8'h00;
    n = 0;
    k = 0;
    for (int i = 0; i < 8; i++) begin
      if (glob ? i == 0 : select_valid[i] &&
          ((hi ^ select_base[i]) & ~select_mask[i]) == 16'h0000) begin
        hits[i] = 1'b1;
        n++;
        k = i;
      end
    end
    w = glob ? strap[1:0] : (n == 1 ? port_width[k] : 2'h0);
    aa = glob ? strap[2] : (n == 1 && auto_acknowledge[k]);
    oe = !(rd && n > 0);
    xfer_valid = 1'b1;
    xfer_read = rd;
    xfer_size = sz;
    xfer_addr = {hi, 14'(rnd()), a};
    #18;
    chk("oe_early", 16'h1, 16'(output_enable_n));
    @(negedge clock);
    #1;
    chk("oe_fall", 16'(oe), 16'(output_enable_n));
    tick();
    chk("select_n", {8'h00, ~hits}, 16'(select_n));
    le = n ? lanes_exp(w, sz, a) : 4'hF;
    chk("lanes", 16'(le), 16'(lane_strobe_n));
    chk("external", 16'(n != 1 || !aa), 16'(access_external));
    chk("boot_global", 16'(glob), 16'(boot_global));
    if (n > 0) chk("width", 16'(w), 16'(active_width));
    if (n > 0)
      chk("burst", 16'(n == 1 && !glob && (rd ? burst_r[k] : burst_w[k])),
          16'(active_burst));
    if (n == 1) chk("aa", 16'(aa), 16'(active_auto_ack));
    if (n == 1 && (!glob || aa))
      chk("wait", glob ? 16'hF : 16'(select_wait[k]),
          16'(active_wait));
    if (n == 1)
      chk("mode", 16'(glob ? strap[2] : lane_strobe_mode[k]),
          16'(lane_write_mode));
    xfer_valid = 1'b0;
    #18;
    chk("oe_hold", 16'(oe), 16'(output_enable_n));
    @(negedge clock);
    #1;
    chk("oe_idle", 16'h1, 16'(output_enable_n));
    tick();
    chk("idle", 16'h0FFF, {lane_strobe_n, select_n});
  endtask

  task automatic strap_up(input logic [2:0] s);
    select_valid = 8'h00;
    reset_input_n = 1'b0;
    data_pin_in = {s, 5'(rnd())};
    strap = s;
    glob = 1'b1;
    tick();
    reset_input_n = 1'b1;
    tick();
    tick();
  endtask

  task automatic stop_test();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  initial begin
    #200000;
    bad_count++;
    stop_test();
  end

  initial begin
    rng = 32'h000166FE;
    {bad_count, compares} = '0;
    {reset, reset_input_n, glob, strap} = 6'h38;
    {xfer_valid, xfer_read, xfer_addr, xfer_size} = '0;
    {data_pin_in, select_valid, lane_strobe_mode} = '0;
    {auto_acknowledge, burst_r, burst_w} = '0;
    {select_base, select_mask, port_width, select_wait} = '0;
    repeat (2) tick();
    reset = 1'b0;
    foreach (data_pin_in[s]) begin
      strap_up(3'(s));
      repeat (8) access(1'(rnd()), 16'(rnd()), 2'(rnd()));
    end
    for (int i = 0; i < 8; i++) select_base[i] = 16'(i) << 12;
    select_base[7] = 16'h0000;
    select_mask[7] = 16'h0001;
    select_valid = 8'hFF;
    glob = 1'b0;
    tick();
    repeat (150) begin
      {port_width, lane_strobe_mode, auto_acknowledge} = 32'(rnd());
      {select_wait, burst_r, burst_w} = 48'({rnd(), rnd()});
      access(1'(rnd()), 16'(rnd()) & 16'h7001, 2'(rnd()));
    end
    select_valid = 8'h00;
    data_pin_in = 8'h40;
    strap = 3'h2;
    glob = 1'b1;
    reset = 1'b1;
    #1;
    chk("reset", 16'h1FFF,
        {output_enable_n, lane_strobe_n, select_n});
    tick();
    reset = 1'b0;
    tick();
    tick();
    repeat (4) access(1'b1, 16'(rnd()), 2'(rnd()));
    chk("oe_faults", 16'h0, 16'(oe_faults));
    stop_test();
  end
endmodule
